// >>> verilog/rtcp_regs.svh
`ifndef RTCP_REGS_SVH
`define RTCP_REGS_SVH
// ----------------------------------------
// Host port select codes
// ----------------------------------------
`define RTCP_SEL_STD_IDX 2'h0
`define RTCP_SEL_STD_DAT 2'h1
`define RTCP_SEL_EXT_IDX 2'h2
`define RTCP_SEL_EXT_DAT 2'h3
// ----------------------------------------
// Register indices
// ----------------------------------------
`define RTCP_IDX_SECONDS_ALARM    7'h01
`define RTCP_IDX_MINUTES_ALARM    7'h03
`define RTCP_IDX_HOURS_ALARM    7'h05
`define RTCP_IDX_MDAY    7'h07
`define RTCP_IDX_MON     7'h08
`define RTCP_IDX_CTLA    7'h0A
`define RTCP_IDX_CTLB    7'h0B
`define RTCP_IDX_CTLC    7'h0C
`define RTCP_IDX_CTLD    7'h0D
`define RTCP_IDX_MAX     7'h7F
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define RTCP_UIP_BIT     7
`define RTCP_DV_HI       6
`define RTCP_DV_LO       4
`define RTCP_RS_HI       3
`define RTCP_RS_LO       0
`define RTCP_DV_NORMAL   3'h2
`define RTCP_DV_STOP_HI  2'h0
`define RTCP_EN_PER      6
`define RTCP_EN_ALM      5
`define RTCP_EN_UPD      4
`define RTCP_FL_IRQ      7
`define RTCP_FL_PER      6
`define RTCP_FL_ALM      5
`define RTCP_FL_UPD      4
`define RTCP_PVF_BIT     7
`define RTCP_ALM_ANY     2'h3
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RTCP_CTLA_RST    8'h20
`define RTCP_ZERO8       8'h00
`define RTCP_CLK_NS      10
`define RTCP_UIP_NS      244000
`define RTCP_ALM_NS      30500
`define RTCP_LOCK_MIN_NS 62000000
`define RTCP_LOCK_MAX_NS 125000000
`define RTCP_SEC_NS      1000000000
`endif

// >>> verilog/rtcp_pkg.sv
package rtcp_pkg;
  // Input lockout states
  typedef enum logic [1:0]
  {
    RTCP_LOCKED = 2'b00,
    RTCP_WAIT   = 2'b01,
    RTCP_OPEN   = 2'b10
  } rtcp_lock_t;
  // Whole state of the block
  typedef struct packed {
    logic [4:0]         sync1;
    logic [4:0]         sync2;
    rtcp_lock_t         lock;
    logic [31:0]        lock_cnt;
    logic [31:0]        sec_cnt;
    logic [15:0]        alm_cnt;
    logic               alm_pend;
    logic [6:0]         std_idx;
    logic [6:0]         ext_idx;
    logic [7:0]         ctla;
    logic [7:0]         ctlb;
    logic [7:0]         ctlc;
    logic               pvf;
    logic [7:0]         mday_alarm;
    logic [7:0]         mon_alarm;
    logic [7:0]         century;
    logic [127:0][7:0]  std_ram;
    logic [127:0][7:0]  ext_ram;
    logic [7:0]         rdata;
    logic               rvalid;
  } rtcp_state_t;
endpackage

// >>> verilog/rtcp_top.sv
`timescale 1ns/100ps
// Operation
// RULE_01 - Supply loss clears power valid flag
// RULE_02 - Reading power valid flag sets it
// RULE_03 - Host checks flag, initialises if zero
// RULE_04 - Ignore host inputs below on threshold
// RULE_05 - Hold lockout 62 to 125 ms
// RULE_06 - Normal divider code ends lockout at once
// RULE_07 - Low battery plus reset: open, init
// RULE_08 - Zero power valid flag opens at once
// RULE_09 - Divider code 00X stops oscillator; here only while on battery with the system supply below threshold
// RULE_10 - Stopped oscillator: no time, no events
// RULE_11 - One request line, enabled events only
// RULE_12 - Flag register read clears all flags
// RULE_13 - Flags hold one occurrence only
// RULE_14 - Update busy bit leads update 244 us
// RULE_15 - Alarm flag 30.5 us after update
// RULE_16 - Periodic flag half period plus lead
// RULE_17 - Low indices overlay time and control
// RULE_18 - Indirect access through index, data
// RULE_19 - Second pair reaches extended RAM
// RULE_20 - No access on battery, writes need flag
// RULE_21 - Three registers overlay programmable bytes
// RULE_22 - Software uses read-modify-write
// RULE_23 - Alarm compare after each update
// RULE_24 - Control B bit 6 enables periodic
// RULE_25 - Supply status inputs are synchronised
`include "rtcp_regs.svh"
module rtcp_top
#(
  parameter int SEC_CYC  = `RTCP_SEC_NS / `RTCP_CLK_NS,
  parameter int UIP_CYC  = (`RTCP_UIP_NS + `RTCP_CLK_NS - 1) / `RTCP_CLK_NS,
  parameter int LOCK_CYC =
    (`RTCP_LOCK_MIN_NS + `RTCP_CLK_NS - 1) / `RTCP_CLK_NS,
  parameter int PER_SHIFT = 12
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Supply status
  input  wire logic       sys_above_on,
  input  wire logic       on_battery,
  input  wire logic       supply_lost,
  input  wire logic       battery_below_detect,
  input  wire logic       host_hw_reset,
  // Overlay configuration
  input  wire logic       cfg_overlay_en,
  input  wire logic [6:0] cfg_mday_alarm_idx,
  input  wire logic [6:0] cfg_mon_alarm_idx,
  input  wire logic [6:0] cfg_century_idx,
  // Host index and data ports
  input  wire logic [1:0] host_sel,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic [7:0] host_wdata,
  output logic      [7:0] host_rdata,
  output logic            host_rvalid,
  // Status outputs
  output logic            irq,
  output logic            lockout,
  output logic            osc_enable
);
  // ----------------------------------------
  // Derived counts
  // ----------------------------------------
  localparam int ALM_CYC =
    (`RTCP_ALM_NS + `RTCP_CLK_NS - 1) / `RTCP_CLK_NS;
  localparam int HALF_CYC = SEC_CYC / 2;
  // ----------------------------------------
  // State
  // ----------------------------------------
  rtcp_pkg::rtcp_state_t s;       // Registered state
  rtcp_pkg::rtcp_state_t next_s;  // Next state
  logic        sys_on;            // Synchronised status
  logic        batt_only;
  logic        lost;
  logic        bat_low;
  logic        hw_rst;
  logic        dv_norm;           // Divider counting
  logic        osc_run;           // Oscillator running
  logic        run;               // Timekeeping active
  logic        upd;               // Update event
  logic        per_hit;           // Periodic event
  logic        alm_hit;           // Alarm event
  logic        match;             // Alarm compare
  logic        fast_open;         // Skip lockout delay
  logic        acc_ok;            // Host access allowed
  logic [31:0] to_upd;            // Cycles to update
  logic [31:0] per_len;           // Periodic interval
  logic [31:0] phase;             // Offset in interval
  logic [6:0]  idx;               // Selected data index

  // Alarm field match or wildcard
  function automatic logic fmatch(input logic [7:0] a,
                                  input logic [7:0] v);
    fmatch = (a[7:6] == `RTCP_ALM_ANY) || (a == v);
  endfunction

  // Standard location read view
  function automatic logic [7:0] std_view(
    input rtcp_pkg::rtcp_state_t st, input logic ovl,
    input logic [6:0] i, input logic [6:0] i_md,
    input logic [6:0] i_mo, input logic [6:0] i_ce);
    std_view = st.std_ram[i];
    if (ovl && i == i_md)
      std_view = st.mday_alarm; // RULE_21
    else if (ovl && i == i_mo)
      std_view = st.mon_alarm;
    else if (ovl && i == i_ce)
      std_view = st.century;
    else if (i == `RTCP_IDX_CTLA)
      std_view = st.ctla; // RULE_17
    else if (i == `RTCP_IDX_CTLB)
      std_view = st.ctlb;
    else if (i == `RTCP_IDX_CTLC)
      std_view = st.ctlc;
    else if (i == `RTCP_IDX_CTLD)
      std_view = {st.pvf, 7'h00};
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    // Two-stage status synchroniser
    next_s.sync1 = {host_hw_reset, battery_below_detect, supply_lost,
                    on_battery, sys_above_on}; // RULE_25
    next_s.sync2 = s.sync1;
    sys_on    = s.sync2[0];
    batt_only = s.sync2[1];
    lost      = s.sync2[2];
    bat_low   = s.sync2[3];
    hw_rst    = s.sync2[4];
    // Oscillator gating
    osc_run = !(batt_only && !sys_on &&
                s.ctla[`RTCP_DV_HI:`RTCP_DV_LO+1] ==
                `RTCP_DV_STOP_HI); // RULE_09
    dv_norm = s.ctla[`RTCP_DV_HI:`RTCP_DV_LO] == `RTCP_DV_NORMAL;
    run     = osc_run && dv_norm; // RULE_10
    // Second counter; held at half a second when idle
    to_upd = 32'(SEC_CYC - 1) - s.sec_cnt;
    upd = run && (to_upd == 32'h0);
    if (!dv_norm)
      next_s.sec_cnt = 32'(HALF_CYC);
    else if (run)
      next_s.sec_cnt = upd ? 32'h0 : s.sec_cnt + 32'h1;
    // Update busy flag
    next_s.ctla[`RTCP_UIP_BIT] =
      run && (to_upd < 32'(UIP_CYC)) && !upd; // RULE_14
    // Periodic tap, placed relative to the update
    per_len = 32'h1 << (PER_SHIFT + int'(s.ctla[`RTCP_RS_HI:`RTCP_RS_LO]));
    phase   = (to_upd - 32'(UIP_CYC)) & (per_len - 32'h1);
    per_hit = run && (s.ctla[`RTCP_RS_HI:`RTCP_RS_LO] != 4'h0) &&
              (to_upd >= 32'(UIP_CYC)) &&
              (phase == (per_len >> 1)); // RULE_16
    // Alarm compare at the update
    match = fmatch(s.std_ram[`RTCP_IDX_SECONDS_ALARM], s.std_ram[0]) &&
            fmatch(s.std_ram[`RTCP_IDX_MINUTES_ALARM], s.std_ram[2]) &&
            fmatch(s.std_ram[`RTCP_IDX_HOURS_ALARM], s.std_ram[4]) &&
            fmatch(s.mday_alarm, s.std_ram[`RTCP_IDX_MDAY]) &&
            fmatch(s.mon_alarm, s.std_ram[`RTCP_IDX_MON]);
    alm_hit = run && s.alm_pend &&
              (s.alm_cnt == 16'(ALM_CYC - 1)); // RULE_15
    if (upd && match)
    begin
      // Start alarm delay
      next_s.alm_pend = 1'b1; // RULE_23
      next_s.alm_cnt  = 16'h0;
    end
    else if (alm_hit || !run)
      next_s.alm_pend = 1'b0; // RULE_10
    else if (s.alm_pend)
      next_s.alm_cnt = s.alm_cnt + 16'h1;
    // Lockout sequencing
    fast_open = dv_norm || !s.pvf ||
                (bat_low && hw_rst); // RULE_06 RULE_08
    case (s.lock)
      rtcp_pkg::RTCP_LOCKED:
      begin
        if (sys_on && fast_open)
          next_s.lock = rtcp_pkg::RTCP_OPEN;
        else if (sys_on)
        begin
          next_s.lock     = rtcp_pkg::RTCP_WAIT;
          next_s.lock_cnt = 32'h0;
        end
      end
      rtcp_pkg::RTCP_WAIT:
      begin
        if (!sys_on)
          next_s.lock = rtcp_pkg::RTCP_LOCKED; // RULE_04
        else if (s.lock_cnt == 32'(LOCK_CYC - 1))
          next_s.lock = rtcp_pkg::RTCP_OPEN; // RULE_05
        else
          next_s.lock_cnt = s.lock_cnt + 32'h1;
      end
      rtcp_pkg::RTCP_OPEN:
      begin
        if (!sys_on)
          next_s.lock = rtcp_pkg::RTCP_LOCKED; // RULE_04
      end
      default:
        next_s.lock = rtcp_pkg::RTCP_LOCKED;
    endcase
    // Host access gate
    acc_ok = (s.lock == rtcp_pkg::RTCP_OPEN) && !batt_only; // RULE_20
    idx = (host_sel == `RTCP_SEL_STD_DAT) ? s.std_idx : s.ext_idx;
    next_s.rvalid = 1'b0;
    if (acc_ok && host_rd)
    begin
      // Indirect read
      next_s.rvalid = 1'b1;
      case (host_sel)
        `RTCP_SEL_STD_IDX: next_s.rdata = {1'b0, s.std_idx};
        `RTCP_SEL_EXT_IDX: next_s.rdata = {1'b0, s.ext_idx};
        `RTCP_SEL_EXT_DAT: next_s.rdata = s.ext_ram[idx]; // RULE_19
        default:
          next_s.rdata = std_view(s, cfg_overlay_en, idx,
                                  cfg_mday_alarm_idx, cfg_mon_alarm_idx,
                                  cfg_century_idx); // RULE_18
      endcase
      if (host_sel == `RTCP_SEL_STD_DAT &&
          idx == `RTCP_IDX_CTLC && !(cfg_overlay_en &&
          (idx == cfg_mday_alarm_idx || idx == cfg_mon_alarm_idx ||
           idx == cfg_century_idx)))
        next_s.ctlc = `RTCP_ZERO8; // RULE_12
      if (host_sel == `RTCP_SEL_STD_DAT && idx == `RTCP_IDX_CTLD)
        next_s.pvf = 1'b1; // RULE_02
    end
    else if (acc_ok && host_wr)
    begin
      case (host_sel)
        `RTCP_SEL_STD_IDX: next_s.std_idx = host_wdata[6:0]; // RULE_18
        `RTCP_SEL_EXT_IDX: next_s.ext_idx = host_wdata[6:0];
        `RTCP_SEL_EXT_DAT:
          if (s.pvf)
            next_s.ext_ram[idx] = host_wdata; // RULE_19 RULE_20
        default:
          if (!s.pvf)
            next_s.std_ram = s.std_ram; // RULE_20
          else if (cfg_overlay_en && idx == cfg_mday_alarm_idx)
            next_s.mday_alarm = host_wdata; // RULE_21
          else if (cfg_overlay_en && idx == cfg_mon_alarm_idx)
            next_s.mon_alarm = host_wdata;
          else if (cfg_overlay_en && idx == cfg_century_idx)
            next_s.century = host_wdata;
          else if (idx == `RTCP_IDX_CTLA)
            next_s.ctla[`RTCP_DV_HI:0] = host_wdata[`RTCP_DV_HI:0];
          else if (idx == `RTCP_IDX_CTLB)
            next_s.ctlb = host_wdata;
          else if (idx != `RTCP_IDX_CTLC && idx != `RTCP_IDX_CTLD)
            next_s.std_ram[idx] = host_wdata; // RULE_17
      endcase
    end
    // Events set flags after the read clear, so a set wins
    if (per_hit)
      next_s.ctlc[`RTCP_FL_PER] = 1'b1; // RULE_13
    if (alm_hit)
      next_s.ctlc[`RTCP_FL_ALM] = 1'b1;
    if (upd)
      next_s.ctlc[`RTCP_FL_UPD] = 1'b1;
    if ((per_hit && s.ctlb[`RTCP_EN_PER]) ||
        (alm_hit && s.ctlb[`RTCP_EN_ALM]) ||
        (upd && s.ctlb[`RTCP_EN_UPD]))
      next_s.ctlc[`RTCP_FL_IRQ] = 1'b1; // RULE_11 RULE_24
    // Initialise low registers on battery-low host reset
    if (s.lock == rtcp_pkg::RTCP_LOCKED && sys_on && bat_low && hw_rst)
    begin
      for (int i = 0; i <= int'(`RTCP_IDX_CTLD); i++)
        next_s.std_ram[i] = `RTCP_ZERO8; // RULE_07
      next_s.ctla = `RTCP_CTLA_RST;
      next_s.ctlb = `RTCP_ZERO8;
      next_s.ctlc = `RTCP_ZERO8;
      next_s.pvf  = 1'b0;
    end
    // Loss of backup supply clears the valid flag
    if (lost)
      next_s.pvf = 1'b0; // RULE_01
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s          <= '0;
      s.ctla     <= `RTCP_CTLA_RST;
      s.lock     <= rtcp_pkg::RTCP_LOCKED;
      s.sec_cnt  <= 32'(HALF_CYC);
    end
    else
      s <= next_s;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign host_rdata  = s.rdata;
  assign host_rvalid = s.rvalid;
  assign irq         = s.ctlc[`RTCP_FL_IRQ]; // RULE_11
  assign lockout     = s.lock != rtcp_pkg::RTCP_OPEN; // RULE_04
  assign osc_enable  = osc_run; // RULE_09

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Read of the valid flag index with access allowed
  sequence crd_read;
    acc_ok && host_rd && host_sel == `RTCP_SEL_STD_DAT &&
    s.std_idx == `RTCP_IDX_CTLD && !lost;
  endsequence
  // Wait phase leaving on its count
  sequence wait_done;
    s.lock == rtcp_pkg::RTCP_WAIT && sys_on &&
    s.lock_cnt == 32'(LOCK_CYC - 1);
  endsequence

  chk_pvf_read_set: assert property (crd_read |=> s.pvf) // RULE_02
    else $error("valid flag not set by read");
  chk_pvf_loss: assert property (lost |=> !s.pvf) // RULE_01
    else $error("valid flag kept after supply loss");
  chk_flag_clear: assert property (
    acc_ok && host_rd && host_sel == `RTCP_SEL_STD_DAT &&
    s.std_idx == `RTCP_IDX_CTLC && !cfg_overlay_en &&
    !per_hit && !alm_hit && !upd
    |=> s.ctlc == `RTCP_ZERO8 && !irq) // RULE_12
    else $error("flags not cleared by read");
  chk_irq_cause: assert property ($rose(irq) |->
    $past(per_hit && s.ctlb[`RTCP_EN_PER] ||
          alm_hit && s.ctlb[`RTCP_EN_ALM] ||
          upd && s.ctlb[`RTCP_EN_UPD])) // RULE_11
    else $error("request without enabled event");
  chk_lock_open: assert property (
    $changed(s.lock) && s.lock == rtcp_pkg::RTCP_OPEN |->
    $past(s.lock) == rtcp_pkg::RTCP_LOCKED && $past(fast_open) ||
    $past(s.lock_cnt) == 32'(LOCK_CYC - 1)) // RULE_05
    else $error("lockout ended early");
  chk_lock_seq: assert property (wait_done |=>
    s.lock == rtcp_pkg::RTCP_OPEN) // RULE_05
    else $error("lockout did not end on count");
  chk_lock_below: assert property (!sys_on |=>
    s.lock == rtcp_pkg::RTCP_LOCKED) // RULE_04
    else $error("inputs open below threshold");
  chk_osc_quiet: assert property (!osc_run |->
    !upd && !per_hit && !alm_hit) // RULE_10
    else $error("event while oscillator stopped");
  chk_wr_block: assert property (
    !s.pvf && s.lock == rtcp_pkg::RTCP_OPEN |=>
    $stable(s.ext_ram) && $stable(s.ctlb)) // RULE_20
    else $error("write taken with valid flag clear");
  chk_uip_lead: assert property (upd |->
    $past(s.ctla[`RTCP_UIP_BIT])) // RULE_14
    else $error("update without busy lead");
  chk_alarm_time: assert property (alm_hit |->
    s.alm_cnt == 16'(ALM_CYC - 1) ##1 s.ctlc[`RTCP_FL_ALM]) // RULE_15
    else $error("alarm flag not set on time");
endmodule

// >>> bench/rtcp_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host model on the index and data ports
// ----------------------------------------
module rtcp_host
(
  // Clock
  input  wire logic       clk,
  // Host bus
  output logic      [1:0] host_sel,
  output logic            host_wr,
  output logic            host_rd,
  output logic      [7:0] host_wdata,
  input  wire logic [7:0] host_rdata,
  input  wire logic       host_rvalid
);
  // Idle bus at time zero
  initial
  begin
    host_sel   = 2'h0;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
    host_wdata = 8'h00;
  end
  // One write strobe, data scrambled after release
  task automatic put(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    host_sel   <= s;
    host_wdata <= d;
    host_wr    <= 1'b1;
    @(posedge clk);
    host_wr    <= 1'b0;
    host_wdata <= ~d;
  endtask
  // One read strobe, answer awaited a few cycles
  task automatic get(input logic [1:0] s, output logic [7:0] d,
                     output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge clk);
    host_sel <= s;
    host_rd  <= 1'b1;
    @(posedge clk);
    host_rd  <= 1'b0;
    repeat (3)
    begin
      @(posedge clk);
      if (host_rvalid === 1'b1 && !ok)
      begin
        ok = 1'b1;
        d  = host_rdata;
      end
    end
  endtask
  // Indexed write: index port first, then data port
  task automatic wr(input logic x, input logic [7:0] i,
                    input logic [7:0] d);
    put({x, 1'b0}, i);
    put({x, 1'b1}, d);
  endtask
  // Indexed read through the same pair
  task automatic rd(input logic x, input logic [7:0] i,
                    output logic [7:0] d, output logic ok);
    put({x, 1'b0}, i);
    get({x, 1'b1}, d, ok);
  endtask
  // Set bits keeping the others as read
  task automatic setb(input logic [7:0] i, input logic [7:0] m);
    logic [7:0] v;
    logic       ok;
    rd(1'b0, i, v, ok);
    wr(1'b0, i, v | m);
  endtask
endmodule

// >>> bench/rtcp_top_bench.sv
`timescale 1ns/100ps
module rtcp_top_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic       clk;           // 100 MHz clock
  logic       srst;          // Synchronous reset
  logic       sys_above_on;  // System supply good
  logic       on_battery;    // Battery only
  logic       supply_lost;   // Both supplies low
  logic       bat_low;       // Battery below detect
  logic       hw_rst;        // Host hardware reset
  logic       ovl_en;        // Overlay enable
  logic [6:0] mday_idx;      // Month-day alarm index
  logic [6:0] mon_idx;       // Month alarm index
  logic [6:0] cen_idx;       // Century index
  logic [1:0] host_sel;      // Port select
  logic       host_wr;       // Write strobe
  logic       host_rd;       // Read strobe
  logic [7:0] host_wdata;    // Write data
  logic [7:0] host_rdata;    // Read data
  logic       host_rvalid;   // Read answer
  logic       irq;           // Request line
  logic       lockout;       // Inputs ignored
  logic       osc_enable;    // Oscillator running
  int         num_errors;    // Mismatches
  int         check_count;   // Comparisons
  logic [7:0] d;             // Scratch read data
  logic       ok;            // Scratch read taken
  // Clock toggles every half period
  initial
    clk = 1'b0;
  always
    #5 clk = ~clk;
  // ----------------------------------------
  // Design and host model
  // ----------------------------------------
  rtcp_top #(.SEC_CYC(4000), .UIP_CYC(100), .LOCK_CYC(50), .PER_SHIFT(4))
    dut (.clk(clk), .srst(srst), .sys_above_on(sys_above_on),
         .on_battery(on_battery), .supply_lost(supply_lost),
         .battery_below_detect(bat_low), .host_hw_reset(hw_rst),
         .cfg_overlay_en(ovl_en), .cfg_mday_alarm_idx(mday_idx),
         .cfg_mon_alarm_idx(mon_idx), .cfg_century_idx(cen_idx),
         .host_sel(host_sel), .host_wr(host_wr), .host_rd(host_rd),
         .host_wdata(host_wdata), .host_rdata(host_rdata),
         .host_rvalid(host_rvalid), .irq(irq), .lockout(lockout),
         .osc_enable(osc_enable));
  rtcp_host host (.clk(clk), .host_sel(host_sel), .host_wr(host_wr),
                  .host_rd(host_rd), .host_wdata(host_wdata),
                  .host_rdata(host_rdata), .host_rvalid(host_rvalid));
  // ----------------------------------------
  // Compare and helper tasks
  // ----------------------------------------
  // Byte compare
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Single bit compare
  task automatic chk1(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  // Indexed read, taken or refused as expected
  task automatic rc(input logic x, input logic [7:0] i,
                    input logic [7:0] e, input logic v);
    host.rd(x, i, d, ok);
    chk1("read taken", v, ok);
    if (v)
      chk8("read data", e, d);
  endtask
  // Bounded wait for a lockout level
  task automatic wlock(input int n, input logic e);
    for (int k = 0; k < n && lockout !== e; k++)
      @(posedge clk);
    chk1("lockout", e, lockout);
  endtask
  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    results;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    num_errors = 0;
    check_count = 0;
    srst = 1'b1;
    sys_above_on = 1'b1;
    on_battery = 1'b0;
    supply_lost = 1'b0;
    bat_low = 1'b0;
    hw_rst = 1'b0;
    ovl_en = 1'b0;
    mday_idx = 7'h0E;
    mon_idx = 7'h0F;
    cen_idx = 7'h30;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    // Flag clear after reset opens at once, reads once as zero
    wlock(6, 1'b0);
    rc(0, 8'h0D, 8'h00, 1);
    rc(0, 8'h0D, 8'h80, 1);
    $display("power flag test done");
    // Both RAMs, index readback, protected registers
    host.wr(0, 8'h20, 8'hA5);
    host.wr(1, 8'h20, 8'h3C);
    rc(0, 8'h20, 8'hA5, 1);
    rc(1, 8'h20, 8'h3C, 1);
    host.put(2'h0, 8'hA0);
    host.get(2'h0, d, ok);
    chk8("index", 8'h20, d);
    host.wr(0, 8'h0C, 8'hFF);
    rc(0, 8'h0C, 8'h00, 1);
    host.wr(0, 8'h0A, 8'hA0);
    rc(0, 8'h0A, 8'h20, 1);
    $display("access test done");
    // Update event, flag clearing, alarm delay, busy lead
    host.setb(8'h0B, 8'h10);
    for (int k = 0; k < 4000 && irq !== 1'b1; k++)
      @(posedge clk);
    chk1("irq", 1'b1, irq);
    rc(0, 8'h0C, 8'h90, 1);
    chk1("irq", 1'b0, irq);
    rc(0, 8'h0C, 8'h00, 1);
    repeat (3000) @(posedge clk);
    rc(0, 8'h0C, 8'h00, 1);
    repeat (40) @(posedge clk);
    rc(0, 8'h0C, 8'h20, 1);
    chk1("irq", 1'b0, irq);
    repeat (800) @(posedge clk);
    rc(0, 8'h0A, 8'h20, 1);
    repeat (60) @(posedge clk);
    rc(0, 8'h0A, 8'hA0, 1);
    $display("update test done");
    // Periodic event on the shared line, after the next update
    for (int k = 0; k < 200 && irq !== 1'b1; k++)
      @(posedge clk);
    rc(0, 8'h0C, 8'h90, 1);
    host.wr(0, 8'h0B, 8'h40);
    host.wr(0, 8'h0A, 8'h21);
    for (int k = 0; k < 80 && irq !== 1'b1; k++)
      @(posedge clk);
    rc(0, 8'h0C, 8'hC0, 1);
    host.wr(0, 8'h0A, 8'h20);
    host.wr(0, 8'h0B, 8'h00);
    $display("periodic test done");
    // Supply loss clears the flag and blocks writes
    supply_lost <= 1'b1;
    repeat (4) @(posedge clk);
    supply_lost <= 1'b0;
    repeat (4) @(posedge clk);
    host.wr(0, 8'h20, 8'h11);
    rc(0, 8'h20, 8'hA5, 1);
    rc(0, 8'h0D, 8'h00, 1);
    on_battery <= 1'b1;
    repeat (4) @(posedge clk);
    rc(0, 8'h20, 8'hA5, 0);
    on_battery <= 1'b0;
    // Let the status synchroniser see the battery-only flag drop
    repeat (4) @(posedge clk);
    $display("supply test done");
    // Lockout timer with divider held
    host.wr(0, 8'h0A, 8'h00);
    host.wr(0, 8'h01, 8'h5A);
    sys_above_on <= 1'b0;
    on_battery <= 1'b1;
    wlock(6, 1'b1);
    chk1("osc", 1'b0, osc_enable);
    rc(0, 8'h20, 8'hA5, 0);
    on_battery <= 1'b0;
    sys_above_on <= 1'b1;
    repeat (40) @(posedge clk);
    chk1("lockout", 1'b1, lockout);
    wlock(30, 1'b0);
    // Low battery with host reset: open and initialise
    sys_above_on <= 1'b0;
    bat_low <= 1'b1;
    hw_rst <= 1'b1;
    wlock(6, 1'b1);
    sys_above_on <= 1'b1;
    wlock(8, 1'b0);
    bat_low <= 1'b0;
    hw_rst <= 1'b0;
    rc(0, 8'h01, 8'h00, 1);
    rc(0, 8'h0A, 8'h20, 1);
    host.rd(0, 8'h0D, d, ok);
    // Normal divider opens at once
    sys_above_on <= 1'b0;
    wlock(6, 1'b1);
    sys_above_on <= 1'b1;
    wlock(8, 1'b0);
    $display("lockout test done");
    // Programmable overlay over a RAM byte
    host.wr(0, 8'h30, 8'hAA);
    ovl_en <= 1'b1;
    host.wr(0, 8'h30, 8'h19);
    rc(0, 8'h30, 8'h19, 1);
    ovl_en <= 1'b0;
    rc(0, 8'h30, 8'hAA, 1);
    $display("overlay test done");
    results;
  end
endmodule
